// *** hdl/abl_alu_defines.vh ***
// constants for the add and bit logic execution datapath
`ifndef ABL_ALU_DEFINES_VH
`define ABL_ALU_DEFINES_VH

// ****************************************************************
// register indices (byte address = index * 4)
// ****************************************************************
`define ABL_IDX_CTRL      10'h000
`define ABL_IDX_STAT      10'h001
`define ABL_IDX_RESULT    10'h002
`define ABL_IDX_FLAGS     10'h0d5

// ****************************************************************
// field positions
// ****************************************************************
`define ABL_FLAG_C        7
`define ABL_FLAG_Z        6
`define ABL_FLAG_S        5
`define ABL_FLAG_V        4
`define ABL_FLAG_D        3
`define ABL_FLAG_H        2
`define ABL_CTRL_EN       0
`define ABL_CTRL_PAGE_LO  4
`define ABL_STAT_BUSY     0
`define ABL_STAT_ILLEGAL  1

// ****************************************************************
// reset values
// ****************************************************************
`define ABL_RST_FLAGS     8'h00
`define ABL_RST_CTRL      8'h01

// ****************************************************************
// operation kinds
// ****************************************************************
`define ABL_KIND_ADD      3'h0
`define ABL_KIND_ADC      3'h1
`define ABL_KIND_AND      3'h2
`define ABL_KIND_BAND     3'h3
`define ABL_KIND_BCMP     3'h4

// ****************************************************************
// opcode fields
// ****************************************************************
`define ABL_HI_ADD        4'h0
`define ABL_HI_ADC        4'h1
`define ABL_HI_AND        4'h5
`define ABL_OP_BAND       8'h67
`define ABL_OP_BCMP       8'h17
`define ABL_LO_RR         4'h2
`define ABL_LO_RIR        4'h3
`define ABL_LO_GG         4'h4
`define ABL_LO_GIG        4'h5
`define ABL_LO_IMM        4'h6

`endif

// *** hdl/abl_flag_calc.v ***
// combinational result and flag computation for one operation
`timescale 1ns/10ps
`default_nettype none
`include "abl_alu_defines.vh"

module abl_flag_calc
(
    input  wire [2:0] kind,      // operation kind
    input  wire [7:0] dst,       // destination operand
    input  wire [7:0] src,       // source operand
    input  wire [2:0] bit_idx,   // bit index b
    input  wire       form,      // bit and form selector
    input  wire [7:0] flags_in,  // current flags
    output reg  [7:0] result,    // value for destination
    output reg  [7:0] flags_out, // updated flags
    output reg        writes     // destination is written
);

    reg       cin;
    reg [8:0] sum;
    reg [4:0] low;
    reg       rbit;

    always @*
    begin
        cin       = (kind == `ABL_KIND_ADC) ? flags_in[`ABL_FLAG_C] : 1'b0;
        sum       = {1'b0, dst} + {1'b0, src} + {8'h00, cin};
        low       = {1'b0, dst[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
        result    = dst;
        flags_out = flags_in;
        writes    = 1'b1;
        rbit      = 1'b0;
        case (kind)
            `ABL_KIND_ADD, `ABL_KIND_ADC:
            begin
                result                = sum[7:0];
                flags_out[`ABL_FLAG_C] = sum[8];
                flags_out[`ABL_FLAG_Z] = (sum[7:0] == 8'h00);
                flags_out[`ABL_FLAG_S] = sum[7];
                flags_out[`ABL_FLAG_V] = (dst[7] == src[7]) && (sum[7] != dst[7]);
                flags_out[`ABL_FLAG_D] = 1'b0;
                flags_out[`ABL_FLAG_H] = low[4];
            end
            `ABL_KIND_AND:
            begin
                result                = dst & src;
                flags_out[`ABL_FLAG_Z] = ((dst & src) == 8'h00);
                flags_out[`ABL_FLAG_S] = dst[7] & src[7];
                flags_out[`ABL_FLAG_V] = 1'b0;
            end
            `ABL_KIND_BAND:
            begin
                if (form == 1'b0)
                begin
                    rbit      = dst[0] & src[bit_idx];
                    result[0] = rbit;
                end
                else
                begin
                    rbit            = dst[bit_idx] & src[0];
                    result[bit_idx] = rbit;
                end
                flags_out[`ABL_FLAG_Z] = ~rbit;
                flags_out[`ABL_FLAG_S] = 1'b0;
            end
            `ABL_KIND_BCMP:
            begin
                writes                = 1'b0;
                flags_out[`ABL_FLAG_Z] = (dst[0] == src[bit_idx]);
                flags_out[`ABL_FLAG_S] = 1'b0;
            end
            default:
            begin
                writes = 1'b0;
            end
        endcase
    end

endmodule // abl_flag_calc

`default_nettype wire

// *** hdl/abl_alu.v ***
// sequencer, operand fetch, flags register and bus slave of the alu group
// Contract
// - adc stores dst plus src plus carry
// - adds set carry, zero, sign from result
// - overflow when same-sign operands flip sign
// - adc half-carry from bit three carry
// - add stores dst plus src, no carry
// - add half-carry from low nibble carry
// - both adds clear decimal-adjust flag
// - and stores dst and src
// - and sets zero, sign; clears overflow
// - bit and has two bit forms
// - bit and touches one bit, flags
// - second byte holds register, bit, form
// - bit compare writes no operand
// - bit compare zero when bits equal
// - flags live at register index d5
`timescale 1ns/10ps
`default_nettype none
`include "abl_alu_defines.vh"

module abl_alu
(
    input  wire        clk,        // core clock, 40 MHz
    input  wire        rst_b,      // synchronous reset, active low
    input  wire        op_valid,   // decoder offers an instruction
    output wire        op_ready,   // block idle and ctrl enable set, takes the instruction
    input  wire [7:0]  op_code,    // opcode byte
    input  wire [7:0]  op_byte2,   // second instruction byte
    input  wire [7:0]  op_byte3,   // third instruction byte
    output reg         op_done,    // one-cycle pulse, operation finished
    output reg         op_illegal, // one-cycle pulse with op_done
    output wire        rf_rd,      // register file read strobe
    output wire [7:0]  rf_addr,    // register file address
    input  wire [7:0]  rf_rdata,   // read data, one cycle after rf_rd
    output reg         rf_wr,      // register file write strobe
    output reg  [7:0]  rf_wdata,   // register file write data
    output reg  [7:0]  flags,      // flags register contents
    input  wire        wb_cyc_i,   // wishbone cycle
    input  wire        wb_stb_i,   // wishbone strobe
    input  wire        wb_we_i,    // wishbone write enable
    input  wire [11:0] wb_adr_i,   // wishbone byte address
    input  wire [3:0]  wb_sel_i,   // wishbone byte selects
    input  wire [31:0] wb_dat_i,   // wishbone write data
    output reg  [31:0] wb_dat_o,   // wishbone read data
    output reg         wb_ack_o    // wishbone acknowledge
);

    // ****************************************************************
    // states
    // ****************************************************************
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_RPTR = 3'h1;
    localparam [2:0] S_GPTR = 3'h2;
    localparam [2:0] S_RSRC = 3'h3;
    localparam [2:0] S_GSRC = 3'h4;
    localparam [2:0] S_RDST = 3'h5;
    localparam [2:0] S_GDST = 3'h6;
    localparam [2:0] S_WRB  = 3'h7;

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [2:0]  kind;
    reg  [7:0]  src_addr;
    reg  [7:0]  dst_addr;
    reg  [7:0]  src_val;
    reg  [7:0]  dst_val;
    reg  [2:0]  bit_idx;
    reg         form;
    reg  [7:0]  ctrl;
    reg         illegal_seen;
    reg  [7:0]  last_result;

    // decoder outputs
    reg  [2:0]  d_kind;
    reg  [7:0]  d_src;
    reg  [7:0]  d_dst;
    reg  [2:0]  d_bit;
    reg         d_form;
    reg         d_ptr;
    reg         d_imm;
    reg         d_ok;

    wire [7:0]  calc_result;
    wire [7:0]  calc_flags;
    wire        calc_writes;
    wire [3:0]  page;
    wire        take;
    wire        wb_req;
    wire        wb_wr;
    wire [9:0]  wb_idx;

    assign page     = ctrl[7:`ABL_CTRL_PAGE_LO];
    assign op_ready = (state == S_IDLE) && ctrl[`ABL_CTRL_EN];
    assign take     = op_valid && op_ready;
    assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr    = wb_req && wb_we_i && wb_sel_i[0];
    assign wb_idx   = wb_adr_i[11:2];

    // ****************************************************************
    // instruction decode
    // ****************************************************************
    always @*
    begin
        d_kind = `ABL_KIND_ADD;
        d_src  = 8'h00;
        d_dst  = 8'h00;
        d_bit  = op_byte2[3:1];
        d_form = op_byte2[0];
        d_ptr  = 1'b0;
        d_imm  = 1'b0;
        d_ok   = 1'b1;
        if (op_code == `ABL_OP_BAND)
        begin
            d_kind = `ABL_KIND_BAND;
            if (op_byte2[0] == 1'b0)
            begin
                d_dst = {page, op_byte2[7:4]};
                d_src = op_byte3;
            end
            else
            begin
                d_src = {page, op_byte2[7:4]};
                d_dst = op_byte3;
            end
        end
        else if (op_code == `ABL_OP_BCMP)
        begin
            d_kind = `ABL_KIND_BCMP;
            d_dst  = {page, op_byte2[7:4]};
            d_src  = op_byte3;
            d_form = 1'b0;
        end
        else
        begin
            case (op_code[7:4])
                `ABL_HI_ADD: d_kind = `ABL_KIND_ADD;
                `ABL_HI_ADC: d_kind = `ABL_KIND_ADC;
                `ABL_HI_AND: d_kind = `ABL_KIND_AND;
                default:     d_ok   = 1'b0;
            endcase
            case (op_code[3:0])
                // odd low codes are the indirect forms
                `ABL_LO_RR, `ABL_LO_RIR:
                begin
                    d_dst = {page, op_byte2[7:4]};
                    d_src = {page, op_byte2[3:0]};
                    d_ptr = op_code[0];
                end
                `ABL_LO_GG, `ABL_LO_GIG:
                begin
                    d_src = op_byte2;
                    d_dst = op_byte3;
                    d_ptr = op_code[0];
                end
                `ABL_LO_IMM:
                begin
                    d_dst = op_byte2;
                    d_src = op_byte3;
                    d_imm = 1'b1;
                end
                default: d_ok = 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // result and flag computation
    // ****************************************************************
    abl_flag_calc u_calc
    (
        .kind      (kind),
        .dst       (dst_val),
        .src       (src_val),
        .bit_idx   (bit_idx),
        .form      (form),
        .flags_in  (flags),
        .result    (calc_result),
        .flags_out (calc_flags),
        .writes    (calc_writes)
    );

    // ****************************************************************
    // register file access
    // ****************************************************************
    assign rf_rd   = (state == S_RPTR) || (state == S_RSRC) || (state == S_RDST);
    assign rf_addr = (state == S_RDST) ? dst_addr : src_addr;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always @*
    begin
        next_state = state;
        case (state)
            S_IDLE:
            begin
                if (take && d_ok)
                begin
                    if (d_ptr)
                        next_state = S_RPTR;
                    else if (d_imm)
                        next_state = S_RDST;
                    else
                        next_state = S_RSRC;
                end
            end
            S_RPTR:  next_state = S_GPTR;
            S_GPTR:  next_state = S_RSRC;
            S_RSRC:  next_state = S_GSRC;
            S_GSRC:  next_state = S_RDST;
            S_RDST:  next_state = S_GDST;
            S_GDST:  next_state = S_WRB;
            S_WRB:   next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            state      <= S_IDLE;
            kind       <= `ABL_KIND_ADD;
            src_addr   <= 8'h00;
            dst_addr   <= 8'h00;
            src_val    <= 8'h00;
            dst_val    <= 8'h00;
            bit_idx    <= 3'h0;
            form       <= 1'b0;
            op_done    <= 1'b0;
            op_illegal <= 1'b0;
            rf_wr      <= 1'b0;
            rf_wdata   <= 8'h00;
        end
        else
        begin
            state      <= next_state;
            op_done    <= 1'b0;
            op_illegal <= 1'b0;
            rf_wr      <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    if (take)
                    begin
                        kind     <= d_kind;
                        src_addr <= d_src;
                        dst_addr <= d_dst;
                        bit_idx  <= d_bit;
                        form     <= d_form;
                        if (d_imm)
                            src_val <= op_byte3;
                        if (!d_ok)
                        begin
                            op_done    <= 1'b1;
                            op_illegal <= 1'b1;
                        end
                    end
                end
                S_GPTR:  src_addr <= rf_rdata;
                S_GSRC:  src_val  <= rf_rdata;
                S_GDST:  dst_val  <= rf_rdata;
                S_WRB:
                begin
                    rf_wr    <= calc_writes;
                    rf_wdata <= calc_result;
                    op_done  <= 1'b1;
                end
                default: op_done <= 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // flags, control and status registers
    // ****************************************************************
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            flags        <= `ABL_RST_FLAGS;
            ctrl         <= `ABL_RST_CTRL;
            illegal_seen <= 1'b0;
            last_result  <= 8'h00;
        end
        else
        begin
            if (state == S_WRB)
            begin
                flags       <= calc_flags;
                last_result <= calc_result;
            end
            else if (wb_wr && (wb_idx == `ABL_IDX_FLAGS))
                flags <= wb_dat_i[7:0];
            if (wb_wr && (wb_idx == `ABL_IDX_CTRL))
                ctrl <= wb_dat_i[7:0];
            // new illegal event wins over a write-one clear
            if (take && !d_ok)
                illegal_seen <= 1'b1;
            else if (wb_wr && (wb_idx == `ABL_IDX_STAT) && wb_dat_i[`ABL_STAT_ILLEGAL])
                illegal_seen <= 1'b0;
        end
    end

    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req && !wb_we_i)
            begin
                case (wb_idx)
                    `ABL_IDX_CTRL:   wb_dat_o <= {24'h000000, ctrl};
                    `ABL_IDX_STAT:   wb_dat_o <= {30'h00000000, illegal_seen,
                                                  (state != S_IDLE)};
                    `ABL_IDX_RESULT: wb_dat_o <= {24'h000000, last_result};
                    `ABL_IDX_FLAGS:  wb_dat_o <= {24'h000000, flags};
                    default:         wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // abl_alu

`default_nettype wire

// *** tb/abl_alu_checker.sv ***
// concurrent checks on the alu group ports
`timescale 1ns/10ps
`default_nettype none
module abl_alu_checker
(
    input wire logic       clk,        // clock
    input wire logic       rst_b,      // reset
    input wire logic       op_valid,   // offer
    input wire logic       op_ready,   // accept
    input wire logic [7:0] op_code,    // opcode
    input wire logic       op_done,    // finish
    input wire logic       op_illegal, // unknown
    input wire logic       rf_wr,      // write
    input wire logic [7:0] rf_wdata,   // result
    input wire logic [7:0] flags,      // flags
    input wire logic       wb_cyc_i,   // cycle
    input wire logic       wb_stb_i,   // strobe
    input wire logic       wb_ack_o    // ack
);
    logic [7:0] cur_op;
    wire logic  in_rng = (cur_op[3:0] >= 4'h2) && (cur_op[3:0] <= 4'h6);
    wire logic  is_add = in_rng && (cur_op[7:5] == 3'h0);
    wire logic  is_and = in_rng && (cur_op[7:4] == 4'h5);
    wire logic  is_bit = (cur_op == 8'h67) || (cur_op == 8'h17);
    wire logic  zs_ok = (flags[6] == (rf_wdata == 8'h00)) && (flags[5] == rf_wdata[7]);
    always @(posedge clk)
    begin
        if (!rst_b)
            cur_op <= 8'h00;
        else if (op_valid && op_ready)
            cur_op <= op_code;
    end
    // ****************
    // assertions
    // ****************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence take_s(logic [3:0] lo);
        op_valid && op_ready && (op_code[3:0] == lo)
            && (op_code[7:5] == 3'h0 || op_code[7:4] == 4'h5);
    endsequence
    sequence finish_s;
        op_done && rf_wr;
    endsequence
    rr_time_a: assert property (take_s(4'h2) |-> ##6 finish_s)
        else $error("register form late");
    ind_time_a: assert property (take_s(4'h3) |-> ##8 finish_s)
        else $error("indirect form late");
    imm_time_a: assert property (take_s(4'h6) |-> ##4 finish_s)
        else $error("immediate form late");
    add_flags_a: assert property (op_done && is_add |-> zs_ok)
        else $error("add zero or sign wrong");
    add_dec_a: assert property (op_done && is_add |-> !flags[3])
        else $error("add left decimal flag");
    and_flags_a: assert property (op_done && is_and |-> zs_ok && !flags[4]
        && flags[7] == $past(flags[7]) && flags[3:2] == $past(flags[3:2]))
        else $error("and flags wrong");
    bit_keep_a: assert property (op_done && is_bit |-> !flags[5]
        && flags[7] == $past(flags[7]) && flags[3:2] == $past(flags[3:2]))
        else $error("bit op flags wrong");
    cmp_nowrite_a: assert property (op_done && cur_op == 8'h17 |-> !rf_wr)
        else $error("bit compare wrote");
    illegal_quiet_a: assert property (op_illegal |-> op_done && !rf_wr && $stable(flags))
        else $error("illegal op had effect");
    wb_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack wrong");
endmodule // abl_alu_checker
bind abl_alu abl_alu_checker u_chk
(
    .clk, .rst_b, .op_valid, .op_ready, .op_code, .op_done, .op_illegal,
    .rf_wr, .rf_wdata, .flags, .wb_cyc_i, .wb_stb_i, .wb_ack_o
);
`default_nettype wire

// *** tb/abl_rf_model.sv ***
// register file model serving operand reads and result writes
`timescale 1ns/10ps
`default_nettype none
module abl_rf_model
(
    input  wire logic       clk,      // clock
    input  wire logic       rf_rd,    // read strobe
    input  wire logic [7:0] rf_addr,  // address
    output var  logic [7:0] rf_rdata, // data, one cycle later
    input  wire logic       rf_wr,    // write strobe
    input  wire logic [7:0] rf_wdata  // write data
);
    logic [7:0] mem [0:255];
    logic [7:0] last_addr;
    initial rf_rdata = 8'h00;
    always @(posedge clk)
    begin
        // released bus shows the inverse of its last value
        rf_rdata <= rf_rd ? mem[rf_addr] : ~rf_rdata;
        if (rf_rd)
            last_addr <= rf_addr;
        // final read names the destination
        if (rf_wr)
            mem[last_addr] <= rf_wdata;
    end
endmodule // abl_rf_model
`default_nettype wire

// *** tb/tb_add_and_bit_logic_alu.sv ***
// self-checking bench for the add and bit logic alu group
`timescale 1ns/10ps
`default_nettype none
`include "abl_alu_defines.vh"
module tb_add_and_bit_logic_alu;
    logic             clk = 1'b0;
    logic             rst_b = 1'b0;
    logic             op_valid = 1'b0;
    logic [7:0]       op_code = 8'h00, op_byte2 = 8'h00, op_byte3 = 8'h00;
    logic             wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [11:0]      wb_adr_i = 12'h000;
    logic [3:0]       wb_sel_i = 4'h1;
    logic [31:0]      wb_dat_i = 32'h0;
    wire logic        op_ready, op_done, op_illegal, rf_rd, rf_wr, wb_ack_o;
    wire logic [7:0]  rf_addr, rf_rdata, rf_wdata, flags;
    wire logic [31:0] wb_dat_o;
    logic             saw_illegal;
    logic [7:0]       fpre;
    int               num_errors = 0;
    int               samples_checked = 0;
    logic [7:0]       dv [2:6] = '{8'h7f, 8'hff, 8'h12, 8'h80, 8'h0f};
    logic [7:0]       sv [2:6] = '{8'h01, 8'h01, 8'h03, 8'h80, 8'hf0};
    always #12.5 clk = ~clk;
    abl_alu u_dut
    (
        .clk, .rst_b, .op_valid, .op_ready, .op_code, .op_byte2, .op_byte3, .op_done,
        .op_illegal, .rf_rd, .rf_addr, .rf_rdata, .rf_wr, .rf_wdata, .flags, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o
    );
    abl_rf_model u_rf
    (
        .clk, .rf_rd, .rf_addr, .rf_rdata, .rf_wr, .rf_wdata
    );
    // ****************
    // tasks
    // ****************
    task automatic report_and_stop;
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // 0 bus ack, 1 ready, 2 done
    task automatic wait_hi(input int which);
        int n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while ((which == 0 ? wb_ack_o : which == 1 ? op_ready : op_done) !== 1'b1 && n < 40);
        if (n >= 40)
        begin
            num_errors++;
            $display("[FAIL] handshake %0d expected 1 seen none", which);
            report_and_stop();
        end
    endtask
    task automatic wb_access(input logic we, input logic [9:0] idx, input logic [7:0] val);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, val};
        wait_hi(0);
        if (!we)
            check8("wb read", val, wb_dat_o[7:0]);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic run_op(input logic [7:0] code, input logic [7:0] b2, input logic [7:0] b3);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= code;
        op_byte2 <= b2;
        op_byte3 <= b3;
        wait_hi(1);
        op_valid <= 1'b0;
        wait_hi(2);
        saw_illegal = op_illegal;
        @(negedge clk);
    endtask
    task automatic do_op(input logic [3:0] hi, input logic [3:0] lo);
        logic [7:0] d, s, r, ef;
        logic [8:0] sum;
        logic [4:0] hs;
        d = dv[lo];
        s = sv[lo];
        sum = d + s + (hi == 4'h1);
        hs = d[3:0] + s[3:0] + (hi == 4'h1);
        r = (hi == 4'h5) ? (d & s) : sum[7:0];
        ef = {sum[8], r == 8'h00, r[7], d[7] == s[7] && r[7] != d[7], 1'b0, hs[4], 2'b11};
        if (hi == 4'h5)
            ef = {1'b1, r == 8'h00, r[7], 5'b01011};
        u_rf.mem[8'h01] = d;
        u_rf.mem[8'h21] = d;
        u_rf.mem[8'h02] = lo[0] ? 8'h30 : s;
        u_rf.mem[8'h22] = lo[0] ? 8'h30 : s;
        u_rf.mem[8'h30] = s;
        // carry and decimal set beforehand
        wb_access(1'b1, `ABL_IDX_FLAGS, 8'h8b);
        run_op({hi, lo}, lo < 4'h4 ? 8'h12 : (lo == 4'h6 ? 8'h21 : 8'h22),
               lo == 4'h6 ? s : 8'h21);
        check8("result", r, u_rf.mem[lo < 4'h4 ? 8'h01 : 8'h21]);
        check8("source", lo[0] ? 8'h30 : s, u_rf.mem[lo < 4'h4 ? 8'h02 : 8'h22]);
        check8("flags", ef, flags);
    endtask
    task automatic do_bit(input logic [7:0] code, b2, b3, w, x, ew, ex, input logic z);
        u_rf.mem[{4'h0, b2[7:4]}] = w;
        u_rf.mem[b3] = x;
        wb_access(1'b1, `ABL_IDX_FLAGS, 8'hff);
        run_op(code, b2, b3);
        check8("working", ew, u_rf.mem[{4'h0, b2[7:4]}]);
        check8("register", ex, u_rf.mem[b3]);
        check8("flags", {1'b1, z, 6'b001111}, flags & 8'hef);
    endtask
    // ****************
    // sequence
    // ****************
    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        wb_access(1'b0, `ABL_IDX_FLAGS, 8'h00);
        wb_access(1'b0, `ABL_IDX_CTRL, 8'h01);
        wb_access(1'b0, 10'h3ff, 8'h00);
        for (int h = 0; h < 3; h++)
            for (int l = 2; l <= 6; l++)
                do_op(h == 2 ? 4'h5 : h[3:0], l[3:0]);
        do_bit(8'h67, 8'h12, 8'h41, 8'h07, 8'h05, 8'h06, 8'h05, 1'b1);
        wb_access(1'b0, `ABL_IDX_RESULT, 8'h06);
        do_bit(8'h67, 8'h1e, 8'h41, 8'h07, 8'h80, 8'h07, 8'h80, 1'b0);
        do_bit(8'h67, 8'h43, 8'h41, 8'h06, 8'hf2, 8'h06, 8'hf0, 1'b1);
        do_bit(8'h17, 8'h12, 8'h41, 8'h07, 8'h01, 8'h07, 8'h01, 1'b0);
        do_bit(8'h17, 8'h12, 8'h41, 8'h07, 8'h02, 8'h07, 8'h02, 1'b1);
        fpre = flags;
        run_op(8'hff, 8'h00, 8'h00);
        check8("illegal", 8'h01, {7'h00, saw_illegal});
        check8("flags kept", fpre, flags);
        wb_access(1'b0, `ABL_IDX_STAT, 8'h02);
        wb_access(1'b1, `ABL_IDX_STAT, 8'h02);
        wb_access(1'b0, `ABL_IDX_STAT, 8'h00);
        wb_access(1'b1, `ABL_IDX_CTRL, 8'h00);
        @(negedge clk);
        check8("ready off", 8'h00, {7'h00, op_ready});
        wb_access(1'b1, `ABL_IDX_CTRL, 8'h01);
        wb_access(1'b1, `ABL_IDX_FLAGS, 8'h55);
        wb_access(1'b0, `ABL_IDX_FLAGS, 8'h55);
        report_and_stop();
    end
endmodule // tb_add_and_bit_logic_alu
`default_nettype wire
